// File: gmc_pad_model.sv
`timescale 1ns/1ns
`default_nettype none
// pad wires seen by the host: a driver wins, then a pull, else a float
module gmc_pad_model (
  // clock
  input  wire logic       clk,
  // design pad side
  input  wire logic [2:0] pad_out,
  input  wire logic [2:0] pad_oe,
  input  wire logic [2:0] pad_pu,
  input  wire logic [2:0] pad_pd,
  // resolved wire level
  output logic      [2:0] pad_lvl
);
  logic [2:0] flt; // float pattern, never a stable guess
  initial flt = 3'h5;
  // an undriven, unpulled wire toggles so a stale level cannot pass
  always @(posedge clk) flt <= ~flt;
  // resolve each wire from all parties
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (pad_oe[i]) pad_lvl[i] = pad_out[i];
      else if (pad_pu[i]) pad_lvl[i] = 1'b1;
      else if (pad_pd[i]) pad_lvl[i] = 1'b0;
      else pad_lvl[i] = flt[i];
    end
  end
endmodule
`default_nettype wire

// File: gmc_pin_cell.sv
`timescale 1ns/1ns
`default_nettype none
// one pad: function routing, pull and drive, input synchroniser
module gmc_pin_cell import gmc_pkg::*; #(
  parameter int unsigned PIN_INDEX = 0
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // configuration and sources
  input  wire logic [7:0] cfg,
  input  wire logic       shutdown,
  input  wire logic       por_active,
  input  wire logic       mcu_clock,
  input  wire logic       strength_above,
  input  wire logic       direct_out,
  // pad side
  input  wire logic       pad_in,
  output logic            pad_out,
  output logic            pad_oe,
  output logic            pad_pullup,
  output logic            pad_pulldown,
  output logic [1:0]      pad_drive,
  output logic            pad_sync
);

  typedef struct packed {
    logic       sync1;     // first synchroniser stage
    logic       sync2;     // second stage, the only one logic reads
    logic       out;
    logic       oe;
    logic       pu;
    logic       pd;
    logic [1:0] drv;
  } gmc_pin_s;

  gmc_pin_s cur, nxt;
  logic [4:0] sel;
  logic [1:0] route;

  assign sel   = cfg[CFG_SEL_LSB +: CFG_SEL_W];
  assign route = gmc_route(sel, PIN_INDEX, por_active, mcu_clock, strength_above, direct_out);

  // next pad state
  always_comb begin
    nxt       = cur;
    nxt.sync1 = pad_in;
    nxt.sync2 = cur.sync1;
    nxt.drv   = cfg[CFG_DRV_LSB +: 2];                   // R04
    if (shutdown) begin                                  // R02
      nxt.out = 1'b0;
      nxt.oe  = 1'b0;
      nxt.pu  = 1'b0;
      nxt.pd  = 1'b1;
    end else begin
      nxt.oe  = route[1];                                // R03 R11 R13
      nxt.out = route[0];
      nxt.pu  = cfg[CFG_PULLUP_BIT];                     // R01
      nxt.pd  = 1'b0;
    end
  end

  // state register; pads start pulled low and undriven
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur <= '{sync1: 1'b0, sync2: 1'b0, out: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b1, drv: 2'b00};
    end else begin
      cur <= nxt;
    end
  end

  assign pad_out      = cur.out;
  assign pad_oe       = cur.oe;
  assign pad_pullup   = cur.pu;
  assign pad_pulldown = cur.pd;
  assign pad_drive    = cur.drv;
  assign pad_sync     = cur.sync2;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_SHUTDOWN_LOW: assert property (shutdown |=> pad_pulldown && !pad_oe && !pad_out && !pad_pullup) // R02
    else $error("pad not pulled low in shutdown");
  AST_STRENGTH_PIN: assert property (!shutdown && sel[3:0] == FN_STRENGTH_LOW |=> pad_oe && pad_out == $past(strength_above)) // R11
    else $error("pad does not follow strength flag");
  AST_DEFAULT_FN: assert property (!shutdown && sel == FN_DEFAULT && PIN_INDEX == 1 |=> pad_out == !$past(por_active)) // R03
    else $error("default function wrong on pin 1");
  AST_DRIVE: assert property (##1 pad_drive == $past(cfg[CFG_DRV_LSB +: 2])) // R04
    else $error("drive strength not taken from config");

endmodule
`default_nettype wire

// File: gmc_pin_mux_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// register-level bench for the pin multiplexer and clear channel block
module gmc_pin_mux_tb_top import gmc_pkg::*; ;
  localparam int unsigned PER = 4; // short bit period keeps the run brief
  logic        mclk, nrst, hsel, hwrite, hreadyout, hresp, irq;
  logic        pre_eval, shutdown, por, mcu_clk;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [7:0]  str_in, rd;
  logic [2:0]  pin_in, pin_out, pin_oe, pin_pu, pin_pd;
  logic [5:0]  pin_drv;
  int          num_errors, checks_done;

  gmc_pin_mux_top #(.PERIOD_CYCLES(PER)) dut (
    .MCLK(mclk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .STRENGTH_IN(str_in), .PREAMBLE_EVAL(pre_eval), .SHUTDOWN(shutdown),
    .POR_ACTIVE(por), .MCU_CLOCK(mcu_clk), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .PIN_PULLUP(pin_pu), .PIN_PULLDOWN(pin_pd),
    .PIN_DRIVE(pin_drv), .IRQ(irq));

  gmc_pad_model pads (
    .clk(mclk), .pad_out(pin_out), .pad_oe(pin_oe), .pad_pu(pin_pu),
    .pad_pd(pin_pd), .pad_lvl(pin_in));

  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // verdict, reached from the main flow and from any timeout
  task results;
    $display("mismatches %0d of %0d checks", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // wait for hready under a bound
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      results();
    end
  endtask

  // one single-word transfer; read data lands in rd
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'b00};
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    wait_rdy();
    rd = hrdata[7:0];
  endtask

  // compare one value
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // read a register and compare it
  task rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(nm, e, rd);
  endtask

  // let pad outputs land, then step off the edge
  task settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // new strength, read only after a full refresh interval has passed
  task load(input logic [7:0] v);
    @(posedge mclk);
    str_in <= v;
    repeat (4 * PER + 2) @(posedge mclk);
    #1;
  endtask

  // one-cycle preamble evaluation strobe
  task pulse;
    @(posedge mclk);
    pre_eval <= 1'b1;
    @(posedge mclk);
    pre_eval <= 1'b0;
    settle();
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    results();
  end

  // main sequence; no converter-input code is ever selected
  initial begin
    num_errors = 0;
    checks_done = 0;
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    str_in = 8'h00;
    pre_eval = 1'b0;
    shutdown = 1'b0;
    por = 1'b1;
    mcu_clk = 1'b1;
    rd = 8'h00;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    settle();
    // defaults after reset
    chk("oe", 8'h07, {5'h0, pin_oe});
    chk("out", 8'h05, {5'h0, pin_out});
    chk("drive", 8'h00, {2'h0, pin_drv});
    rchk("enable", IDX_ENABLE, ENABLE_RST);
    for (int i = 0; i < 3; i++) rchk("cfg", IDX_PIN0 + 8'(i), 8'h00);
    rchk("thresh", IDX_THRESH, 8'h00);
    rchk("status", IDX_STATUS, 8'h00);
    rchk("unmapped", 8'h3F, 8'h00);
    @(posedge mclk);
    por <= 1'b0;
    mcu_clk <= 1'b0;
    settle();
    chk("out", 8'h02, {5'h0, pin_out});
    // drive sizes, pull-up and an unlisted code on every pin
    bus(1'b1, IDX_PIN0, 8'hC5);
    bus(1'b1, IDX_PIN1, 8'h65);
    bus(1'b1, IDX_PIN2, 8'h9F);
    rchk("cfg1", IDX_PIN1, 8'h65);
    settle();
    chk("drive", 8'h27, {2'h0, pin_drv});
    chk("pullup", 8'h02, {5'h0, pin_pu});
    chk("out", 8'h00, {5'h0, pin_out});
    chk("oe", 8'h07, {5'h0, pin_oe});
    // pin0 as pulled-up input, pin2 follows its port bit
    bus(1'b1, IDX_PIN0, 8'h23);
    bus(1'b1, IDX_PORT, 8'h04);
    bus(1'b1, IDX_PIN2, 8'h0A);
    settle();
    rchk("port", IDX_PORT, 8'h05);
    chk("oe", 8'h06, {5'h0, pin_oe});
    chk("out2", 8'h01, {7'h0, pin_out[2]});
    // threshold compare: equal is not above
    bus(1'b1, IDX_THRESH, 8'h40);
    bus(1'b1, IDX_PIN0, 8'h0E);
    bus(1'b1, IDX_PIN1, 8'h1E);
    load(8'h40);
    rchk("strength", IDX_STRENGTH, 8'h40);
    chk("resp", 8'h00, {7'h0, hresp});
    pulse();
    rchk("status", IDX_STATUS, 8'h00);
    chk("flagpin", 8'h00, {6'h0, pin_out[1:0]});
    load(8'h41);
    pulse();
    rchk("status", IDX_STATUS, 8'h10);
    chk("flagpin", 8'h03, {6'h0, pin_out[1:0]});
    chk("irq", 8'h00, {7'h0, irq});
    bus(1'b1, IDX_STRENGTH, 8'hFF);
    rchk("strength", IDX_STRENGTH, 8'h41);
    // unmask, then clear by writing one
    bus(1'b1, IDX_ENABLE, 8'h10);
    settle();
    chk("irq", 8'h01, {7'h0, irq});
    bus(1'b1, IDX_STATUS, 8'h10);
    settle();
    chk("irq", 8'h00, {7'h0, irq});
    rchk("status", IDX_STATUS, 8'h00);
    // a fresh event while unmasked raises the interrupt again
    pulse();
    chk("irq", 8'h01, {7'h0, irq});
    rchk("status", IDX_STATUS, 8'h10);
    // shutdown pulls all pads low
    @(posedge mclk);
    shutdown <= 1'b1;
    settle();
    chk("oe", 8'h00, {5'h0, pin_oe});
    chk("pulldown", 8'h07, {5'h0, pin_pd});
    chk("pullup", 8'h00, {5'h0, pin_pu});
    @(posedge mclk);
    shutdown <= 1'b0;
    settle();
    chk("pulldown", 8'h00, {5'h0, pin_pd});
    results();
  end
endmodule
`default_nettype wire

// File: gmc_pin_mux_top.sv
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// R01 - three pins, each with own config register
// R02 - shutdown pulls every pad low
// R03 - code zero: reset, inverted reset, clock
// R04 - drive field sizes driver; configs reset zero
// R05 - host avoids converter input in standby
// R06 - eight-bit strength value, half-decibel steps
// R07 - strength refreshed every four bit periods
// R08 - host reads carefully around refresh hazard
// R09 - writable threshold compared at preamble
// R10 - above threshold sets status flag
// R11 - low bits 1110 route flag to pin
// R12 - strength readable any time, no stall
// R13 - unlisted function codes drive pin low
module gmc_pin_mux_top import gmc_pkg::*; #(
  parameter int unsigned PERIOD_CYCLES = BIT_PERIOD_CYCLES
) (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        NRST,
  // register bus
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // modem and system sources
  input  wire logic [7:0]  STRENGTH_IN,
  input  wire logic        PREAMBLE_EVAL,
  input  wire logic        SHUTDOWN,
  input  wire logic        POR_ACTIVE,
  input  wire logic        MCU_CLOCK,
  // pads
  input  wire logic [2:0]  PIN_IN,
  output logic      [2:0]  PIN_OUT,
  output logic      [2:0]  PIN_OE,
  output logic      [2:0]  PIN_PULLUP,
  output logic      [2:0]  PIN_PULLDOWN,
  output logic      [5:0]  PIN_DRIVE,
  // interrupt
  output logic             IRQ
);

  // register file except strength, and bus tracking, in one record
  typedef struct packed {
    logic                     wr_pend;   // write data phase follows
    logic [7:0]               wr_idx;    // register index of that write
    logic [31:0]              rdata;     // read data for the data phase
    logic                     ready;     // bus ready out
    logic                     resp;      // bus response, always okay
    gmc_byte_t                status;    // sticky event flags
    gmc_byte_t                enable;    // interrupt mask
    logic [NUM_PINS-1:0][7:0] pin_cfg;   // per-pin function, pull, drive
    gmc_byte_t                port;      // port register, direct bits low
    gmc_byte_t                thresh;    // clear channel threshold
    logic                     irq;
  } gmc_top_s;

  localparam gmc_top_s TOP_RST = '{
    wr_pend: 1'b0,
    wr_idx:  8'h00,
    rdata:   32'h0000_0000,
    ready:   1'b1,
    resp:    1'b0,
    status:  8'h00,
    enable:  ENABLE_RST,
    pin_cfg: {NUM_PINS{PIN_CFG_RST}},
    port:    PORT_RST,
    thresh:  THRESH_RST,
    irq:     1'b0
  };

  gmc_top_s cur, nxt;

  // address phase decode
  logic       take;         // transfer accepted this cycle
  logic [7:0] addr_idx;     // word index of the address
  logic       addr_ok;      // address is a mapped register
  logic       upper_zero;   // address bits above the map are clear

  // strength evaluation results
  logic [7:0] strength;
  logic       above;
  logic       strength_set;
  logic       refresh;

  // per-pin synchronised pad inputs
  logic [2:0] pad_sync;

  // read view of the port register: direct-input pins show the pad
  logic [7:0] port_view;

  assign take       = HSEL && HTRANS[1] && HREADY;
  assign addr_idx   = HADDR[ADDR_W-1:2];
  assign upper_zero = (HADDR[31:ADDR_W] == '0) && (HADDR[1:0] == 2'b00);

  // word index to mapped flag
  function automatic logic idx_mapped(input logic [7:0] idx);
    logic m;
    m = 1'b0;
    unique case (idx)
      IDX_STATUS, IDX_ENABLE, IDX_PIN0, IDX_PIN1, IDX_PIN2,
      IDX_PORT, IDX_STRENGTH, IDX_THRESH: m = 1'b1;
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  assign addr_ok = upper_zero && idx_mapped(addr_idx);

  // a pin in direct-input mode reports its pad level instead of the stored bit
  always_comb begin
    port_view = cur.port;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (cur.pin_cfg[i][CFG_SEL_LSB +: CFG_SEL_W] == FN_DIRECT_IN) begin
        port_view[PORT_DIO_LSB + i] = pad_sync[i];
      end
    end
  end

  // register file update, status flags and read data
  always_comb begin
    nxt       = cur;
    nxt.ready = 1'b1;               // zero wait states, reads never stall R12
    nxt.resp  = 1'b0;
    // data phase of a write taken one cycle earlier
    if (cur.wr_pend) begin
      unique case (cur.wr_idx)
        IDX_STATUS: begin
          // write one to clear; a new event in this cycle still lands below
          nxt.status = cur.status & ~HWDATA[7:0];
        end
        IDX_ENABLE: begin
          nxt.enable = HWDATA[7:0];
        end
        IDX_PIN0: begin
          nxt.pin_cfg[0] = HWDATA[7:0];   // R01
        end
        IDX_PIN1: begin
          nxt.pin_cfg[1] = HWDATA[7:0];   // R01
        end
        IDX_PIN2: begin
          nxt.pin_cfg[2] = HWDATA[7:0];   // R01
        end
        IDX_PORT: begin
          nxt.port = HWDATA[7:0];
        end
        IDX_THRESH: begin
          nxt.thresh = HWDATA[7:0];       // R09
        end
        default: begin
          // read-only or unmapped: write is dropped, answer stays okay
        end
      endcase
    end
    // hardware set wins over a clear in the same cycle
    if (strength_set) begin
      nxt.status[STATUS_STRENGTH_BIT] = 1'b1;   // R10
    end
    // address phase: note writes, prepare read data
    nxt.wr_pend = 1'b0;
    if (take) begin
      nxt.wr_pend = HWRITE && addr_ok;
      nxt.wr_idx  = addr_idx;
      nxt.rdata   = 32'h0000_0000;
      if (!HWRITE && addr_ok) begin
        // read from the updated copy so a write just before is seen, except the port register, which reads port_view from the current copy
        unique case (addr_idx)
          IDX_STATUS: begin
            nxt.rdata[7:0] = nxt.status;
          end
          IDX_ENABLE: begin
            nxt.rdata[7:0] = nxt.enable;
          end
          IDX_PIN0: begin
            nxt.rdata[7:0] = nxt.pin_cfg[0];
          end
          IDX_PIN1: begin
            nxt.rdata[7:0] = nxt.pin_cfg[1];
          end
          IDX_PIN2: begin
            nxt.rdata[7:0] = nxt.pin_cfg[2];
          end
          IDX_PORT: begin
            nxt.rdata[7:0] = port_view;
          end
          IDX_STRENGTH: begin
            // no gating: a read on the refresh edge sees the old value R07
            nxt.rdata[7:0] = strength;  // R06 R12
          end
          IDX_THRESH: begin
            nxt.rdata[7:0] = nxt.thresh;
          end
          default: begin
            nxt.rdata = 32'h0000_0000;
          end
        endcase
      end
    end
    // level interrupt from any unmasked sticky flag
    nxt.irq = |(nxt.status & nxt.enable);
  end

  // single state register for the register file and bus tracking; pad and strength state sit in their own modules
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      cur <= TOP_RST;               // R04
    end else begin
      cur <= nxt;
    end
  end

  // strength holder and threshold decision
  gmc_strength_eval #(
    .PERIOD_CYCLES (PERIOD_CYCLES),
    .CNT_W         (16)
  ) u_eval (
    .clk           (MCLK),
    .nrst          (NRST),
    .strength_in   (STRENGTH_IN),
    .preamble_eval (PREAMBLE_EVAL),
    .threshold     (cur.thresh),
    .strength      (strength),
    .above         (above),
    .set_pulse     (strength_set),
    .refresh       (refresh)
  );

  // three pad cells; each differs only in its default function
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    gmc_pin_cell #(
      .PIN_INDEX (g)
    ) u_cell (
      .clk            (MCLK),
      .nrst           (NRST),
      .cfg            (cur.pin_cfg[g]),
      .shutdown       (SHUTDOWN),
      .por_active     (POR_ACTIVE),
      .mcu_clock      (MCU_CLOCK),
      .strength_above (above),
      .direct_out     (cur.port[PORT_DIO_LSB + g]),
      .pad_in         (PIN_IN[g]),
      .pad_out        (PIN_OUT[g]),
      .pad_oe         (PIN_OE[g]),
      .pad_pullup     (PIN_PULLUP[g]),
      .pad_pulldown   (PIN_PULLDOWN[g]),
      .pad_drive      (PIN_DRIVE[2*g +: 2]),
      .pad_sync       (pad_sync[g])
    );
  end

  // bus and interrupt outputs straight from the state register
  assign HRDATA    = cur.rdata;
  assign HREADYOUT = cur.ready;
  assign HRESP     = cur.resp;
  assign IRQ       = cur.irq;

  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  logic read_strength;
  logic write_thresh;
  logic write_pin0;
  assign read_strength = take && !HWRITE && addr_ok && addr_idx == IDX_STRENGTH;
  assign write_thresh  = take && HWRITE && addr_ok && addr_idx == IDX_THRESH;
  assign write_pin0    = take && HWRITE && addr_ok && addr_idx == IDX_PIN0;

  sequence s_thresh_write;
    write_thresh ##1 1'b1;
  endsequence
  sequence s_pin0_write;
    write_pin0 ##1 1'b1;
  endsequence

  AST_STATUS_SET: assert property (strength_set |=> cur.status[STATUS_STRENGTH_BIT]) // R10
    else $error("strength event did not set status");
  AST_IRQ_LEVEL: assert property (strength_set && cur.enable[STATUS_STRENGTH_BIT] |=> ##1 IRQ) // R10
    else $error("unmasked flag did not raise interrupt");
  AST_NO_STALL: assert property (read_strength |-> HREADYOUT ##1 HREADYOUT) // R12
    else $error("strength read stalled");
  AST_STRENGTH_READ: assert property (read_strength |=> HRDATA == {24'h000000, $past(strength)}) // R06
    else $error("strength read data wrong");
  AST_THRESH_WRITE: assert property (s_thresh_write |=> cur.thresh == $past(HWDATA[7:0])) // R09
    else $error("threshold write lost");
  AST_PIN0_WRITE: assert property (s_pin0_write |=> cur.pin_cfg[0] == $past(HWDATA[7:0])) // R01
    else $error("pin 0 config write lost");
  AST_CFG_RESET: assert property ($rose(NRST) |-> cur.pin_cfg == {NUM_PINS{PIN_CFG_RST}}) // R04
    else $error("pin configs not zero after reset");
  AST_UNDEF_LOW: assert property (!SHUTDOWN && cur.pin_cfg[2][CFG_SEL_LSB +: CFG_SEL_W] == 5'h1F |=> PIN_OE[2] && !PIN_OUT[2]) // R13
    else $error("unlisted code did not drive low");

endmodule
`default_nettype wire

// File: gmc_pkg.sv
`default_nettype none
// shared constants for the pin multiplexer and clear channel block
package gmc_pkg;

  // timing: system clock and signal strength refresh
  localparam int unsigned CLK_PERIOD_NS         = 50;     // 20 MHz system clock
  localparam int unsigned REFRESH_WINDOW_NS     = 10;     // strength update window
  localparam int unsigned REFRESH_WINDOW_CYCLES =
    (REFRESH_WINDOW_NS / CLK_PERIOD_NS < 1) ? 1 : REFRESH_WINDOW_NS / CLK_PERIOD_NS;
  localparam int unsigned BIT_PERIOD_NS         = 100000; // one bit at 10 kbps
  localparam int unsigned BIT_PERIOD_CYCLES     = BIT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned BITS_PER_REFRESH      = 4;      // strength refresh every 4 bit periods

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS   = 8'h04;
  localparam logic [7:0] IDX_ENABLE   = 8'h06;
  localparam logic [7:0] IDX_PIN0     = 8'h0B;
  localparam logic [7:0] IDX_PIN1     = 8'h0C;
  localparam logic [7:0] IDX_PIN2     = 8'h0D;
  localparam logic [7:0] IDX_PORT     = 8'h0E;
  localparam logic [7:0] IDX_STRENGTH = 8'h26;
  localparam logic [7:0] IDX_THRESH   = 8'h27;
  localparam int unsigned ADDR_W      = 10;   // decoded byte address bits

  // reset values
  localparam logic [7:0] ENABLE_RST  = 8'h03;
  localparam logic [7:0] PIN_CFG_RST = 8'h00;
  localparam logic [7:0] PORT_RST    = 8'h00;
  localparam logic [7:0] THRESH_RST  = 8'h00;

  // field positions
  localparam int unsigned NUM_PINS            = 3;
  localparam int unsigned CFG_SEL_LSB         = 0;
  localparam int unsigned CFG_SEL_W           = 5;
  localparam int unsigned CFG_PULLUP_BIT      = 5;
  localparam int unsigned CFG_DRV_LSB         = 6;
  localparam int unsigned STATUS_STRENGTH_BIT = 4;
  localparam int unsigned PORT_DIO_LSB        = 0;

  // function select codes
  localparam logic [4:0] FN_DEFAULT      = 5'h00; // per-pin power-on default
  localparam logic [4:0] FN_DIRECT_IN    = 5'h03; // pad is an input, seen in port register
  localparam logic [4:0] FN_DIRECT_OUT   = 5'h0A; // pad follows its port register bit
  localparam logic [3:0] FN_STRENGTH_LOW = 4'hE;  // strength above threshold

  typedef logic [7:0] gmc_byte_t;

  // routes one pin: returns {output enable, output level}
  function automatic logic [1:0] gmc_route(input logic [4:0] sel, input int unsigned pin,
                                           input logic por, input logic mclk,
                                           input logic above, input logic dout);
    logic [1:0] r;
    r = {1'b1, 1'b0};                              // unlisted codes drive low
    if (sel == FN_DEFAULT) begin
      if (pin == 0) r = {1'b1, por};
      else if (pin == 1) r = {1'b1, ~por};
      else r = {1'b1, mclk};
    end else if (sel[3:0] == FN_STRENGTH_LOW) begin
      r = {1'b1, above};
    end else if (sel == FN_DIRECT_OUT) begin
      r = {1'b1, dout};
    end else if (sel == FN_DIRECT_IN) begin
      r = {1'b0, 1'b0};
    end
    return r;
  endfunction

endpackage
`default_nettype wire

// File: gmc_strength_eval.sv
`timescale 1ns/1ns
`default_nettype none
// signal strength holder, refresh divider and threshold compare
module gmc_strength_eval import gmc_pkg::*; #(
  parameter int unsigned PERIOD_CYCLES = BIT_PERIOD_CYCLES,
  parameter int unsigned CNT_W         = 16
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // modem side
  input  wire logic [7:0] strength_in,
  input  wire logic       preamble_eval,
  input  wire logic [7:0] threshold,
  // results
  output logic [7:0]      strength,
  output logic            above,
  output logic            set_pulse,
  output logic            refresh
);

  typedef struct packed {
    logic [CNT_W-1:0] bit_cnt;   // cycles within one bit period
    logic [1:0]       bit_num;   // bit periods within one refresh
    logic [7:0]       value;
    logic             above;
    logic             set;
    logic             refresh;
  } gmc_eval_s;

  gmc_eval_s cur, nxt;

  // divider and compare
  always_comb begin
    nxt         = cur;
    nxt.set     = 1'b0;
    nxt.refresh = 1'b0;
    if (cur.bit_cnt == CNT_W'(PERIOD_CYCLES - 1)) begin
      nxt.bit_cnt = '0;
      nxt.bit_num = cur.bit_num + 2'd1;
      if (cur.bit_num == 2'(BITS_PER_REFRESH - 1)) begin
        nxt.value   = strength_in;                        // R07
        nxt.refresh = 1'b1;
      end
    end else begin
      nxt.bit_cnt = cur.bit_cnt + CNT_W'(1);
    end
    // decision taken on the value held when the preamble is judged
    if (preamble_eval) begin                              // R09
      nxt.above = cur.value > threshold;
      nxt.set   = cur.value > threshold;                  // R10
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign strength  = cur.value;                           // R06
  assign above     = cur.above;
  assign set_pulse = cur.set;
  assign refresh   = cur.refresh;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_judge;
    preamble_eval && strength > threshold;
  endsequence
  AST_COMPARE: assert property (s_judge |=> set_pulse && above) // R09
    else $error("strength above threshold not flagged");
  AST_NO_FALSE_SET: assert property (preamble_eval && strength <= threshold |=> !set_pulse && !above) // R10
    else $error("flag set below threshold");
  AST_REFRESH_ONLY: assert property (!$stable(strength) |-> refresh) // R07
    else $error("strength changed outside refresh");

endmodule
`default_nettype wire
